// *** src/atw_pkg.sv ***
// Purpose: Shared constants and types for the timer event, mask and wake block
// Assumes: 32-bit APB data, one word per register
// Notes:   Offsets are byte addresses
`default_nettype none

package atw_pkg;

  // Register offsets
  localparam logic [7:0] OFF_STATUS     = 8'h08;
  localparam logic [7:0] OFF_STAT_CLEAR = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] OFF_IRQ_DIS    = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h18;
  localparam logic [7:0] OFF_WAKE_EN    = 8'h1C;
  localparam logic [7:0] OFF_ALARM_0    = 8'h20;
  localparam logic [7:0] OFF_ALARM_1    = 8'h24;
  localparam logic [7:0] OFF_PER_INT_0  = 8'h30;

  // Source bit positions
  localparam int BIT_CLK_DONE = 29;
  localparam int BIT_READY    = 25;
  localparam int BIT_BUSY     = 24;
  localparam int BIT_PER_1    = 17;
  localparam int BIT_PER_0    = 16;
  localparam int BIT_ALARM_0  = 8;
  localparam int BIT_WRAP     = 0;

  // Implemented bits and reset values
  localparam logic [31:0] MASK_BITS   = 32'h2203_0301;
  localparam logic [31:0] WAKE_BITS   = 32'h0003_0301;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;
  localparam int          TAP_W       = 5;
  localparam logic [TAP_W-1:0] TAP_RESET = 5'h00;
  localparam int          NUM_ALARMS  = 2;

  // Timer core inputs seen by this block
  typedef struct packed {
    logic        busy;
    logic        clk_busy;
    logic        wrap;
    logic [31:0] counter;
    logic [31:0] prescaler;
  } atw_tmr_in_s;

endpackage : atw_pkg

`default_nettype wire

// *** src/atw_event_regs.sv ***
// Purpose: Interrupt mask, status flags, wake gating, alarms and periodic tap for a timer
// Assumes: APB slave at pclk, timer core inputs synchronous to pclk
// Notes:   One access cycle per transfer, no wait states
//
// How it works
// - Writing one to a disable-port bit clears that mask bit
// - Zero bits written to the disable port leave mask bits alone
// - Enable-port ones set mask bits; mask is read-only and resets to zero
// - Mask bit one enables its source at bits 29,25,17,16,9,8,0
// - While busy, wake, alarm, interval writes ignored and reads return zero
// - Wake-enable register gates which events drive the wakeup output; resets zero
// - Periodic wake bit set: selected prescaler bit rising asserts wakeup
// - Alarm wake bit set: counter reaching alarm value asserts wakeup
// - Overflow wake bit set: counter overflow asserts wakeup
// - Two 32-bit alarm registers; alarm fires when counter equals value
// - Interval field bits 4..0 picks prescaler bit; its rise sets periodic flag
// - Enable port is write-only; zero bits written have no effect
// - While busy, writes to status clear and event registers are discarded
// - Alarm flag set on match, cleared by writing one to status clear
`default_nettype none

module atw_event_regs (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // Timer core
  input  wire atw_pkg::atw_tmr_in_s tmr,
  // Events out
  output logic                     irq,
  output logic                     wakeup
);

  // State
  logic [31:0]              irq_mask_q, irq_mask_d;
  logic [31:0]              status_q, status_d;
  logic [31:0]              wake_enable_q, wake_enable_d;
  logic [31:0]              alarm_q [atw_pkg::NUM_ALARMS];
  logic [31:0]              alarm_d [atw_pkg::NUM_ALARMS];
  logic [atw_pkg::TAP_W-1:0] tap_sel_q, tap_sel_d;
  logic                     tap_prev_q, tap_prev_d;
  logic [atw_pkg::NUM_ALARMS-1:0] match_prev_q, match_prev_d;
  logic                     busy_prev_q, busy_prev_d;
  logic                     clk_busy_prev_q, clk_busy_prev_d;
  logic                     pready_q, pready_d;
  logic                     pslverr_q, pslverr_d;
  logic [31:0]              prdata_q, prdata_d;
  logic                     irq_q, irq_d;
  logic                     wakeup_q, wakeup_d;

  // Decoded strobes and events
  logic                     setup;
  logic                     wr_done;
  logic                     mapped;
  logic [atw_pkg::NUM_ALARMS-1:0] match_now;
  logic [atw_pkg::NUM_ALARMS-1:0] alarm_hit;
  logic                     tap_now;
  logic                     per_rise;
  logic [31:0]              ev_set;

  assign setup   = psel && !penable;
  assign wr_done = psel && penable && pready_q && pwrite;

  // Equality compare per alarm, edge so a held value fires once
  genvar g;
  generate
    for (g = 0; g < atw_pkg::NUM_ALARMS; g++) begin : g_alarm
      assign match_now[g] = (tmr.counter == alarm_q[g]);
      assign alarm_hit[g] = match_now[g] && !match_prev_q[g];
    end
  endgenerate

  assign tap_now  = tmr.prescaler[tap_sel_q];
  assign per_rise = tap_now && !tap_prev_q;

  always_comb begin
    ev_set = atw_pkg::RESET_WORD;
    ev_set[atw_pkg::BIT_WRAP]     = tmr.wrap;
    ev_set[atw_pkg::BIT_PER_0]    = per_rise;
    ev_set[atw_pkg::BIT_READY]    = busy_prev_q && !tmr.busy;
    ev_set[atw_pkg::BIT_CLK_DONE] = clk_busy_prev_q && !tmr.clk_busy;
    ev_set[atw_pkg::BIT_ALARM_0 +: atw_pkg::NUM_ALARMS] = alarm_hit;
  end

  always_comb begin
    mapped = (paddr == atw_pkg::OFF_STATUS)     || (paddr == atw_pkg::OFF_STAT_CLEAR) ||
             (paddr == atw_pkg::OFF_IRQ_ENABLE) || (paddr == atw_pkg::OFF_IRQ_DIS)    ||
             (paddr == atw_pkg::OFF_IRQ_MASK)   || (paddr == atw_pkg::OFF_WAKE_EN)    ||
             (paddr == atw_pkg::OFF_ALARM_0)    || (paddr == atw_pkg::OFF_ALARM_1)    ||
             (paddr == atw_pkg::OFF_PER_INT_0);
  end

  // Next-state for registers, flags and bus answer
  always_comb begin
    irq_mask_d      = irq_mask_q;
    wake_enable_d   = wake_enable_q;
    alarm_d         = alarm_q;
    tap_sel_d       = tap_sel_q;
    tap_prev_d      = tap_now;
    match_prev_d    = match_now;
    busy_prev_d     = tmr.busy;
    clk_busy_prev_d = tmr.clk_busy;
    status_d        = status_q;
    pready_d        = setup;
    pslverr_d       = setup && !mapped;
    prdata_d        = atw_pkg::RESET_WORD;

    if (wr_done) begin
      if (paddr == atw_pkg::OFF_IRQ_ENABLE) begin
        irq_mask_d = irq_mask_q | (pwdata & atw_pkg::MASK_BITS);
      end else if (paddr == atw_pkg::OFF_IRQ_DIS) begin
        irq_mask_d = irq_mask_q & ~pwdata;
      end else if (paddr == atw_pkg::OFF_STAT_CLEAR && !tmr.busy) begin
        status_d = status_q & ~pwdata;
      end else if (paddr == atw_pkg::OFF_WAKE_EN && !tmr.busy) begin
        wake_enable_d = pwdata & atw_pkg::WAKE_BITS;
      end else if (paddr == atw_pkg::OFF_ALARM_0 && !tmr.busy) begin
        alarm_d[0] = pwdata;
      end else if (paddr == atw_pkg::OFF_ALARM_1 && !tmr.busy) begin
        alarm_d[1] = pwdata;
      end else if (paddr == atw_pkg::OFF_PER_INT_0 && !tmr.busy) begin
        tap_sel_d = pwdata[atw_pkg::TAP_W-1:0];
      end
    end

    // New events win over a clear in the same cycle
    status_d = (status_d | ev_set) & atw_pkg::MASK_BITS;

    // Read data captured in setup, held through the access cycle
    if (setup && !pwrite) begin
      if (paddr == atw_pkg::OFF_STATUS) begin
        prdata_d = status_q;
        prdata_d[atw_pkg::BIT_BUSY] = tmr.busy;
      end else if (paddr == atw_pkg::OFF_IRQ_MASK) begin
        prdata_d = irq_mask_q;
      end else if (paddr == atw_pkg::OFF_WAKE_EN && !tmr.busy) begin
        prdata_d = wake_enable_q;
      end else if (paddr == atw_pkg::OFF_ALARM_0 && !tmr.busy) begin
        prdata_d = alarm_q[0];
      end else if (paddr == atw_pkg::OFF_ALARM_1 && !tmr.busy) begin
        prdata_d = alarm_q[1];
      end else if (paddr == atw_pkg::OFF_PER_INT_0 && !tmr.busy) begin
        prdata_d = {27'h000_0000, tap_sel_q};
      end else begin
        prdata_d = atw_pkg::RESET_WORD;
      end
    end

    // Irq from current state so flag and irq stay one cycle apart; wakeup from this cycle's events, same edge as the flag
    irq_d    = |(status_q & irq_mask_q);
    wakeup_d = |(ev_set & wake_enable_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q      <= atw_pkg::RESET_WORD;
      status_q        <= atw_pkg::RESET_WORD;
      wake_enable_q   <= atw_pkg::RESET_WORD;
      alarm_q[0]      <= atw_pkg::RESET_WORD;
      alarm_q[1]      <= atw_pkg::RESET_WORD;
      tap_sel_q       <= atw_pkg::TAP_RESET;
      tap_prev_q      <= 1'b0;
      match_prev_q    <= '0;
      busy_prev_q     <= 1'b0;
      clk_busy_prev_q <= 1'b0;
      pready_q        <= 1'b0;
      pslverr_q       <= 1'b0;
      prdata_q        <= atw_pkg::RESET_WORD;
      irq_q           <= 1'b0;
      wakeup_q        <= 1'b0;
    end else begin
      irq_mask_q      <= irq_mask_d;
      status_q        <= status_d;
      wake_enable_q   <= wake_enable_d;
      alarm_q         <= alarm_d;
      tap_sel_q       <= tap_sel_d;
      tap_prev_q      <= tap_prev_d;
      match_prev_q    <= match_prev_d;
      busy_prev_q     <= busy_prev_d;
      clk_busy_prev_q <= clk_busy_prev_d;
      pready_q        <= pready_d;
      pslverr_q       <= pslverr_d;
      prdata_q        <= prdata_d;
      irq_q           <= irq_d;
      wakeup_q        <= wakeup_d;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;
  assign irq     = irq_q;
  assign wakeup  = wakeup_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_ier, wr_idr;
  assign wr_ier = wr_done && (paddr == atw_pkg::OFF_IRQ_ENABLE);
  assign wr_idr = wr_done && (paddr == atw_pkg::OFF_IRQ_DIS);

  sequence s_read_setup(logic [7:0] a);
    setup && !pwrite && paddr == a;
  endsequence

  sequence s_busy_read;
    setup && !pwrite && tmr.busy &&
      (paddr == atw_pkg::OFF_WAKE_EN || paddr == atw_pkg::OFF_ALARM_0 ||
       paddr == atw_pkg::OFF_ALARM_1 || paddr == atw_pkg::OFF_PER_INT_0);
  endsequence

  property p_idr_clears;
    wr_idr |=> (irq_mask_q & $past(pwdata)) == 32'h0000_0000;
  endproperty
  a_idr_clears: assert property (p_idr_clears) else $error("disable port left a mask bit set");

  property p_idr_keeps;
    wr_idr |=> (irq_mask_q | $past(pwdata)) == ($past(irq_mask_q) | $past(pwdata));
  endproperty
  a_idr_keeps: assert property (p_idr_keeps) else $error("disable port changed a zero bit");

  property p_ier_sets;
    wr_ier |=> ((irq_mask_q & $past(pwdata) & atw_pkg::MASK_BITS) ==
                ($past(pwdata) & atw_pkg::MASK_BITS)) && ((irq_mask_q & ~atw_pkg::MASK_BITS) == 0);
  endproperty
  a_ier_sets: assert property (p_ier_sets) else $error("enable port did not set mask");

  property p_irq_follows;
    (|(status_q & irq_mask_q)) [*2] |-> irq_q;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq low with masked flag");

  property p_irq_quiet;
    !(|(status_q & irq_mask_q)) |=> !irq_q;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq high with no enabled flag");

  property p_busy_read_zero;
    s_busy_read |=> pready && prdata == 32'h0000_0000;
  endproperty
  a_busy_read_zero: assert property (p_busy_read_zero) else $error("busy read not zero");

  property p_busy_write_drop;
    wr_done && tmr.busy |=> $stable(wake_enable_q) && $stable(tap_sel_q) &&
      $stable(alarm_q[0]) && $stable(alarm_q[1]);
  endproperty
  a_busy_write_drop: assert property (p_busy_write_drop) else $error("busy write took effect");

  property p_wake_gate;
    !(|(ev_set & wake_enable_q)) |=> !wakeup_q;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wakeup without enabled event");

  property p_wake_periodic;
    per_rise && wake_enable_q[atw_pkg::BIT_PER_0] |=> wakeup_q;
  endproperty
  a_wake_periodic: assert property (p_wake_periodic) else $error("periodic wake missing");

  property p_wake_alarm;
    alarm_hit[0] && wake_enable_q[atw_pkg::BIT_ALARM_0] |=> wakeup_q;
  endproperty
  a_wake_alarm: assert property (p_wake_alarm) else $error("alarm wake missing");

  property p_wake_wrap;
    tmr.wrap && wake_enable_q[atw_pkg::BIT_WRAP] |=> wakeup_q;
  endproperty
  a_wake_wrap: assert property (p_wake_wrap) else $error("overflow wake missing");

  property p_alarm_flag;
    (alarm_hit != '0) |=> (status_q[atw_pkg::BIT_ALARM_0 +: atw_pkg::NUM_ALARMS] &
                           $past(alarm_hit)) == $past(alarm_hit);
  endproperty
  a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag not set");

  property p_per_flag;
    per_rise |=> status_q[atw_pkg::BIT_PER_0];
  endproperty
  a_per_flag: assert property (p_per_flag) else $error("periodic flag not set");

  property p_port_reads_zero;
    (s_read_setup(atw_pkg::OFF_IRQ_ENABLE) or s_read_setup(atw_pkg::OFF_IRQ_DIS))
      |=> prdata == 32'h0000_0000 && !pslverr;
  endproperty
  a_port_reads_zero: assert property (p_port_reads_zero) else $error("write port read nonzero");

  property p_clear_busy;
    wr_done && tmr.busy && paddr == atw_pkg::OFF_STAT_CLEAR |=>
      (status_q & $past(status_q)) == $past(status_q);
  endproperty
  a_clear_busy: assert property (p_clear_busy) else $error("busy clear took effect");

  property p_ready_answer;
    setup |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("no ready after setup");

  property p_ready_single;
    pready |=> !pready;
  endproperty
  a_ready_single: assert property (p_ready_single) else $error("ready held too long");

  property p_unmapped_err;
    setup && !mapped |=> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

  property p_wake_alarm_1;
    alarm_hit[1] && wake_enable_q[atw_pkg::BIT_ALARM_0 + 1] |=> wakeup_q;
  endproperty
  a_wake_alarm_1: assert property (p_wake_alarm_1) else $error("alarm 1 wake missing");

  property p_wrap_flag;
    tmr.wrap |=> status_q[atw_pkg::BIT_WRAP];
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("overflow flag not set");

  property p_ready_flag;
    $fell(tmr.busy) |=> status_q[atw_pkg::BIT_READY];
  endproperty
  a_ready_flag: assert property (p_ready_flag) else $error("ready flag not set");

  property p_clk_done_flag;
    $fell(tmr.clk_busy) |=> status_q[atw_pkg::BIT_CLK_DONE];
  endproperty
  a_clk_done_flag: assert property (p_clk_done_flag) else $error("clock flag not set");

  property p_wake_write;
    wr_done && !tmr.busy && paddr == atw_pkg::OFF_WAKE_EN |=>
      wake_enable_q == ($past(pwdata) & atw_pkg::WAKE_BITS);
  endproperty
  a_wake_write: assert property (p_wake_write) else $error("wake write lost");

  property p_alarm_write;
    wr_done && !tmr.busy && paddr == atw_pkg::OFF_ALARM_1 |=>
      alarm_q[1] == $past(pwdata);
  endproperty
  a_alarm_write: assert property (p_alarm_write) else $error("alarm write lost");

  property p_tap_write;
    wr_done && !tmr.busy && paddr == atw_pkg::OFF_PER_INT_0 |=>
      tap_sel_q == $past(pwdata[atw_pkg::TAP_W-1:0]);
  endproperty
  a_tap_write: assert property (p_tap_write) else $error("interval write lost");

endmodule // atw_event_regs

`default_nettype wire

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the timer event, mask and wake block
// Assumes: Zero-wait APB slave; timer core inputs driven by the bench
// Notes:   Wakeup pulses are counted, not sampled, so short pulses are never missed
`default_nettype none

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 pclk, presetn, psel, penable, pwrite;
  logic                 pready, pslverr, irq, wakeup, rerr;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rdat;
  atw_pkg::atw_tmr_in_s tmr;
  int                   n_mismatch, checked, n_wake;

  atw_event_regs atw_event_regs_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .tmr(tmr), .irq(irq), .wakeup(wakeup));

  always #4 pclk = ~pclk;

  // Count pulses so a missed or doubled pulse shows as a wrong total
  always @(posedge pclk) begin
    if (wakeup === 1'b1) n_wake <= n_wake + 1;
  end

  task automatic summarize();
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Entered just after a rising edge; one idle cycle after each transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready and data are read at the edge itself, before the slave updates them
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH t=%0t no ready", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee = 1'b0);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(rdat, e)
    `CHK(rerr, ee)
  endtask

  task automatic wake_chk(input int e);
    repeat (4) @(posedge pclk);
    `CHK(n_wake, e)
  endtask

  task automatic irq_chk(input logic e);
    repeat (4) @(posedge pclk);
    `CHK(irq, e)
  endtask

  initial begin
    repeat (6000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; tmr = '0;
    n_mismatch = 0; checked = 0; n_wake = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(atw_pkg::OFF_IRQ_MASK, atw_pkg::RESET_WORD);
    rd(atw_pkg::OFF_WAKE_EN, atw_pkg::RESET_WORD);
    rd(atw_pkg::OFF_ALARM_0, atw_pkg::RESET_WORD);
    rd(atw_pkg::OFF_ALARM_1, atw_pkg::RESET_WORD);
    rd(atw_pkg::OFF_PER_INT_0, atw_pkg::RESET_WORD);
    rd(atw_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
    rd(atw_pkg::OFF_IRQ_DIS, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000, 1'b1);
    // Alarms match the zero counter right after reset
    wr(atw_pkg::OFF_STAT_CLEAR, 32'hFFFF_FFFF);
    rd(atw_pkg::OFF_STATUS, 32'h0000_0000);
    wr(atw_pkg::OFF_IRQ_ENABLE, 32'h0000_0100);
    wr(atw_pkg::OFF_IRQ_ENABLE, 32'h0000_0001);
    rd(atw_pkg::OFF_IRQ_MASK, 32'h0000_0101);
    wr(atw_pkg::OFF_IRQ_ENABLE, 32'hFFFF_FFFF);
    rd(atw_pkg::OFF_IRQ_MASK, atw_pkg::MASK_BITS);
    wr(atw_pkg::OFF_IRQ_DIS, 32'h0000_0100);
    rd(atw_pkg::OFF_IRQ_MASK, atw_pkg::MASK_BITS & 32'hFFFF_FEFF);
    wr(atw_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    rd(atw_pkg::OFF_IRQ_MASK, atw_pkg::MASK_BITS & 32'hFFFF_FEFF);
    irq_chk(1'b0);
    wr(atw_pkg::OFF_WAKE_EN, 32'hFFFF_FFFF);
    rd(atw_pkg::OFF_WAKE_EN, atw_pkg::WAKE_BITS);
    wr(atw_pkg::OFF_WAKE_EN, 32'h0000_0101);
    wr(atw_pkg::OFF_ALARM_0, 32'h0000_0100);
    wr(atw_pkg::OFF_ALARM_1, 32'hFFFF_FFFF);
    rd(atw_pkg::OFF_ALARM_0, 32'h0000_0100);
    rd(atw_pkg::OFF_ALARM_1, 32'hFFFF_FFFF);
    wr(atw_pkg::OFF_PER_INT_0, 32'hFFFF_FFFF);
    rd(atw_pkg::OFF_PER_INT_0, 32'h0000_001F);
    wr(atw_pkg::OFF_PER_INT_0, 32'h0000_0003);
    tmr.wrap <= 1'b1;
    @(posedge pclk);
    tmr.wrap <= 1'b0;
    wake_chk(1);
    rd(atw_pkg::OFF_STATUS, 32'h0000_0001);
    irq_chk(1'b1);
    wr(atw_pkg::OFF_STAT_CLEAR, 32'h0000_0001);
    irq_chk(1'b0);
    // Alarm 0 flag with its mask bit off must stay quiet
    tmr.counter <= 32'h0000_0100;
    wake_chk(2);
    rd(atw_pkg::OFF_STATUS, 32'h0000_0100);
    irq_chk(1'b0);
    wr(atw_pkg::OFF_IRQ_ENABLE, 32'h0000_0100);
    irq_chk(1'b1);
    wr(atw_pkg::OFF_STAT_CLEAR, 32'h0000_0100);
    rd(atw_pkg::OFF_STATUS, 32'h0000_0000);
    tmr.counter <= 32'hFFFF_FFFF;
    wake_chk(2);
    rd(atw_pkg::OFF_STATUS, 32'h0000_0200);
    tmr.prescaler <= 32'h0000_0004;
    wake_chk(2);
    rd(atw_pkg::OFF_STATUS, 32'h0000_0200);
    tmr.prescaler <= 32'h0000_0008;
    wake_chk(2);
    rd(atw_pkg::OFF_STATUS, 32'h0001_0200);
    wr(atw_pkg::OFF_WAKE_EN, 32'h0001_0101);
    tmr.prescaler <= 32'h0000_0000;
    @(posedge pclk);
    tmr.prescaler <= 32'h0000_0008;
    wake_chk(3);
    // Busy drops setting writes, including the status clear
    tmr.busy <= 1'b1;
    @(posedge pclk);
    wr(atw_pkg::OFF_WAKE_EN, 32'h0000_0000);
    wr(atw_pkg::OFF_ALARM_0, 32'h0000_0000);
    wr(atw_pkg::OFF_PER_INT_0, 32'h0000_0000);
    wr(atw_pkg::OFF_STAT_CLEAR, 32'hFFFF_FFFF);
    rd(atw_pkg::OFF_WAKE_EN, 32'h0000_0000);
    rd(atw_pkg::OFF_ALARM_0, 32'h0000_0000);
    rd(atw_pkg::OFF_PER_INT_0, 32'h0000_0000);
    rd(atw_pkg::OFF_STATUS, 32'h0101_0200);
    tmr.busy <= 1'b0;
    @(posedge pclk);
    rd(atw_pkg::OFF_WAKE_EN, 32'h0001_0101);
    rd(atw_pkg::OFF_ALARM_0, 32'h0000_0100);
    rd(atw_pkg::OFF_PER_INT_0, 32'h0000_0003);
    rd(atw_pkg::OFF_STATUS, 32'h0201_0200);
    // Clock-ready has no wake bit, so the wake count must not move
    tmr.clk_busy <= 1'b1;
    @(posedge pclk);
    tmr.clk_busy <= 1'b0;
    wake_chk(3);
    rd(atw_pkg::OFF_STATUS, 32'h2201_0200);
    wr(atw_pkg::OFF_STAT_CLEAR, 32'hFFFF_FFFF);
    irq_chk(1'b0);
    summarize();
  end
endmodule // tb

`default_nettype wire
